// [rtl/umac_pkg.sv]
// Types shared by the widening MAC block
`default_nettype none
package umac_pkg;

	// Decoded instruction as handed over by issue
	typedef struct packed {
		logic multi_src; // 1: per-group second source
		logic [1:0] group_code; // 0: one, 1: two, 2: four groups
		logic [4:0] first_source_field;
		logic [3:0] second_source_field;
		logic [1:0] row_select_reg_field;
		logic [2:0] three_bit_offset_field;
		logic [1:0] two_bit_offset_field;
	} umac_issue_t;

	// Sequencer states
	typedef enum logic [1:0] {
		UMAC_IDLE = 2'b00,
		UMAC_READ = 2'b01,
		UMAC_ROW0 = 2'b10,
		UMAC_ROW1 = 2'b11
	} umac_state_t;

endpackage : umac_pkg
`default_nettype wire

// [rtl/umac_regs.svh]
// Register offsets, field positions and reset values of the widening MAC block
`ifndef UMAC_REGS_SVH
`define UMAC_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UMAC_CTRL_OFF 8'h00
`define UMAC_STATUS_OFF 8'h04
`define UMAC_MASK_OFF 8'h08
`define UMAC_INFO_OFF 8'h0c
`define UMAC_ZAIDX_OFF 8'h10
`define UMAC_ZADATA_OFF 8'h14

// ----------------------------------------------------------------
// Control bits
// ----------------------------------------------------------------
`define UMAC_CTRL_FEAT_BIT 0
`define UMAC_CTRL_STREAM_BIT 1
`define UMAC_CTRL_ARRAY_BIT 2
`define UMAC_CTRL_W 3
`define UMAC_CTRL_RESET 3'h0

// ----------------------------------------------------------------
// Status / mask bits, same layout
// ----------------------------------------------------------------
`define UMAC_ST_DONE_BIT 0
`define UMAC_ST_TRAP_BIT 1
`define UMAC_ST_UNDEF_BIT 2
`define UMAC_ST_W 3
`define UMAC_ST_RESET 3'h0

// ----------------------------------------------------------------
// Array window index fields
// ----------------------------------------------------------------
`define UMAC_ZAIDX_ROW_LSB 0
`define UMAC_ZAIDX_WORD_LSB 8
`define UMAC_ZAIDX_RESET 16'h0000

// ----------------------------------------------------------------
// Decode constants
// ----------------------------------------------------------------
`define UMAC_ROWSEL_PREFIX 3'h2
`define UMAC_ROWS_PER_BYTE 8
`define UMAC_ELEM_BITS 32
`define UMAC_SRC_BITS 16

`endif

// [rtl/umac_top.sv]
// Unsigned widening multiply-accumulate into the matrix accumulator array
//
// Function
// - Multiply 16-bit pairs, widen, accumulate 32-bit
// - One/two/four groups single, two/four multi
// - Row base register is 8 plus select
// - Vectors VL/8, stride vectors over groups
// - Start row is base+offset modulo stride
// - Start row forced even
// - One group: offset is 3-bit field times 2
// - Two/four groups: 2-bit field times 2
// - Single form: consecutive first sources wrap 32
// - Single form: one second source 0-15
// - Multi form: fields scaled, source base plus r
// - Row i takes source elements 2e+i
// - Full 32-bit product, wraparound add, no flags
// - Next group row base advances by stride
// - Undefined when extension not implemented
`default_nettype none
`include "umac_regs.svh"

module umac_top
	import umac_pkg::*;
#(
	parameter int VL = 128 // Vector length in bits, power of two
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic issue_valid,
	output logic issue_ready,
	input wire umac_issue_t issue_op,
	output logic [4:0] x_rd_idx,
	input wire logic [31:0] x_rd_data,
	output logic [4:0] z_rd_idx_a,
	output logic [4:0] z_rd_idx_b,
	input wire logic [VL-1:0] z_rd_data_a,
	input wire logic [VL-1:0] z_rd_data_b,
	output logic op_done,
	output logic op_trap,
	output logic op_undef,
	output logic busy,
	output logic irq
);

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int VECTORS = VL / `UMAC_ROWS_PER_BYTE;
	localparam int RW = $clog2(VECTORS); // Row index width
	localparam int ELEMS = VL / `UMAC_ELEM_BITS; // 32-bit lanes per row
	localparam int WW = (ELEMS > 1) ? $clog2(ELEMS) : 1; // Word index width

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	umac_state_t state, next_state; // Sequencer
	logic [2:0] grp_left, next_grp_left; // Groups still to do
	logic [4:0] n_reg, next_n_reg; // First source of current group
	logic [4:0] m_reg, next_m_reg; // Second source of current group
	logic multi, next_multi; // Form of the running op
	logic [RW-1:0] gbase, next_gbase; // Even start row of current group
	logic [RW:0] stride, next_stride; // Row stride
	logic [VL-1:0] op_a, next_op_a; // Latched first source
	logic [VL-1:0] op_b, next_op_b; // Latched second source
	logic next_op_done, next_op_trap, next_op_undef;
	logic [VL-1:0] za [VECTORS]; // Matrix accumulator array
	logic za_we; // Row write strobe
	logic [RW-1:0] za_row; // Row being updated
	logic [VL-1:0] za_wdata; // Updated row

	// Register file
	logic [`UMAC_CTRL_W-1:0] ctrl, next_ctrl;
	logic [`UMAC_ST_W-1:0] status, next_status;
	logic [`UMAC_ST_W-1:0] mask, next_mask;
	logic [15:0] zaidx, next_zaidx;
	logic [31:0] next_prdata;

	// Decode helpers
	logic [1:0] gsh; // log2 of group count
	logic [3:0] offset; // Immediate row offset
	logic [32:0] row_sum; // Base plus offset, no 32-bit wrap
	logic [RW:0] dec_stride;
	logic [RW-1:0] dec_vec;
	logic legal; // Form and group count allowed
	logic accept; // Issue handshake this cycle

	// ----------------------------------------------------------------
	// Issue decode
	// ----------------------------------------------------------------
	assign issue_ready = (state == UMAC_IDLE);
	assign accept = issue_valid && issue_ready;
	assign busy = (state != UMAC_IDLE);
	// Scalar register read, combinational from the register file
	assign x_rd_idx = {`UMAC_ROWSEL_PREFIX, issue_op.row_select_reg_field};

	// Row start arithmetic, from the issue bundle and the row base register value
	always_comb begin
		gsh = issue_op.group_code;
		// Multi form refuses one group; code 3 is never legal
		legal = (issue_op.group_code != 2'd3) &&
			!(issue_op.multi_src && issue_op.group_code == 2'd0);
		if (issue_op.group_code == 2'd0 && !issue_op.multi_src) begin
			offset = {issue_op.three_bit_offset_field, 1'b0};
		end else begin
			offset = {1'b0, issue_op.two_bit_offset_field, 1'b0};
		end
		dec_stride = (RW + 1)'(VECTORS) >> gsh;
		row_sum = {1'b0, x_rd_data} + 33'(offset);
		// Stride is a power of two, so the modulo is a mask
		dec_vec = row_sum[RW-1:0] & RW'(dec_stride - (RW + 1)'(1));
		dec_vec[0] = 1'b0;
	end

	// ----------------------------------------------------------------
	// Vector register read ports, driven from flops
	// ----------------------------------------------------------------
	assign z_rd_idx_a = n_reg;
	assign z_rd_idx_b = m_reg;

	// ----------------------------------------------------------------
	// Lane arithmetic
	// ----------------------------------------------------------------
	// Combinational read of the row, then write of the same row
	always_comb begin
		logic [31:0] prod;
		logic [0:0] sel;
		prod = 32'h0000_0000;
		sel = (state == UMAC_ROW1) ? 1'b1 : 1'b0;
		za_row = gbase + RW'(sel);
		za_we = (state == UMAC_ROW0) || (state == UMAC_ROW1);
		za_wdata = za[za_row];
		for (int e = 0; e < ELEMS; e++) begin
			// Every lane, no predicate
			prod = op_a[(2 * e + sel) * `UMAC_SRC_BITS +: `UMAC_SRC_BITS] *
				op_b[(2 * e + sel) * `UMAC_SRC_BITS +: `UMAC_SRC_BITS];
			// Wraps silently on overflow
			za_wdata[e * 32 +: 32] = za[za_row][e * 32 +: 32] + prod;
		end
	end

	// Array writeback; cleared at reset so the read window never shows unknowns
	// Costs a reset on every storage flop, traded for a defined start state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int r = 0; r < VECTORS; r++) begin
				za[r] <= '0;
			end
		end else if (za_we) begin
			za[za_row] <= za_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_grp_left = grp_left;
		next_n_reg = n_reg;
		next_m_reg = m_reg;
		next_multi = multi;
		next_gbase = gbase;
		next_stride = stride;
		next_op_a = op_a;
		next_op_b = op_b;
		next_op_done = 1'b0;
		next_op_trap = 1'b0;
		next_op_undef = 1'b0;
		case (state)
			UMAC_IDLE: begin
				if (accept) begin
					if (!ctrl[`UMAC_CTRL_FEAT_BIT] || !legal) begin
						// Missing extension or bad form
						next_op_undef = 1'b1;
					end else if (!ctrl[`UMAC_CTRL_STREAM_BIT] ||
						!ctrl[`UMAC_CTRL_ARRAY_BIT]) begin
						// Checked before any row is touched
						next_op_trap = 1'b1;
					end else begin
						next_state = UMAC_READ;
						next_grp_left = 3'd1 << gsh;
						next_multi = issue_op.multi_src;
						next_gbase = dec_vec;
						next_stride = dec_stride;
						if (!issue_op.multi_src) begin
							next_n_reg = issue_op.first_source_field;
							next_m_reg = {1'b0, issue_op.second_source_field};
						end else if (issue_op.group_code == 2'd1) begin
							next_n_reg = {issue_op.first_source_field[3:0], 1'b0};
							next_m_reg = {issue_op.second_source_field[3:0], 1'b0};
						end else begin
							next_n_reg = {issue_op.first_source_field[2:0], 2'b00};
							next_m_reg = {issue_op.second_source_field[2:0], 2'b00};
						end
					end
				end
			end
			UMAC_READ: begin
				// Sources stay latched for both rows of the group
				next_op_a = z_rd_data_a;
				next_op_b = z_rd_data_b;
				next_state = UMAC_ROW0;
			end
			UMAC_ROW0: begin
				next_state = UMAC_ROW1;
			end
			UMAC_ROW1: begin
				next_gbase = gbase + stride[RW-1:0];
				next_n_reg = n_reg + 5'd1;
				if (multi) begin
					next_m_reg = m_reg + 5'd1;
				end
				next_grp_left = grp_left - 3'd1;
				if (grp_left == 3'd1) begin
					next_state = UMAC_IDLE;
					next_op_done = 1'b1;
				end else begin
					next_state = UMAC_READ;
				end
			end
			default: begin
				next_state = UMAC_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= UMAC_IDLE;
			grp_left <= 3'd0;
			n_reg <= 5'd0;
			m_reg <= 5'd0;
			multi <= 1'b0;
			gbase <= '0;
			stride <= '0;
			op_a <= '0;
			op_b <= '0;
			op_done <= 1'b0;
			op_trap <= 1'b0;
			op_undef <= 1'b0;
		end else begin
			state <= next_state;
			grp_left <= next_grp_left;
			n_reg <= next_n_reg;
			m_reg <= next_m_reg;
			multi <= next_multi;
			gbase <= next_gbase;
			stride <= next_stride;
			op_a <= next_op_a;
			op_b <= next_op_b;
			op_done <= next_op_done;
			op_trap <= next_op_trap;
			op_undef <= next_op_undef;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign pready = 1'b1; // Zero wait states
	assign irq = |(status & mask);

	// Register file next values
	always_comb begin
		logic wr;
		logic rd;
		logic [`UMAC_ST_W-1:0] ev;
		wr = psel && penable && pwrite;
		rd = psel && !penable && !pwrite;
		ev = 3'h0;
		ev[`UMAC_ST_DONE_BIT] = op_done;
		ev[`UMAC_ST_TRAP_BIT] = op_trap;
		ev[`UMAC_ST_UNDEF_BIT] = op_undef;
		next_ctrl = ctrl;
		next_mask = mask;
		next_zaidx = zaidx;
		next_status = status;
		next_prdata = prdata;
		// Error answer is combinational so it stands with pready in access
		pslverr = 1'b0;
		if (wr) begin
			case (paddr)
				`UMAC_CTRL_OFF: next_ctrl = pwdata[`UMAC_CTRL_W-1:0];
				`UMAC_STATUS_OFF: next_status = status & ~pwdata[`UMAC_ST_W-1:0];
				`UMAC_MASK_OFF: next_mask = pwdata[`UMAC_ST_W-1:0];
				`UMAC_ZAIDX_OFF: next_zaidx = pwdata[15:0];
				`UMAC_INFO_OFF, `UMAC_ZADATA_OFF: begin
					// Read-only, writes ignored
				end
				default: begin
					// Unmapped
				end
			endcase
		end
		// Set wins over a same-cycle clear
		next_status = next_status | ev;
		// Read data captured in setup, shown in access
		if (rd) begin
			case (paddr)
				`UMAC_CTRL_OFF: next_prdata = 32'(ctrl);
				`UMAC_STATUS_OFF: next_prdata = 32'(status);
				`UMAC_MASK_OFF: next_prdata = 32'(mask);
				`UMAC_INFO_OFF: next_prdata = {29'h0, busy, state};
				`UMAC_ZAIDX_OFF: next_prdata = {16'h0000, zaidx};
				`UMAC_ZADATA_OFF: next_prdata = za[zaidx[`UMAC_ZAIDX_ROW_LSB +: RW]]
					[32 * zaidx[`UMAC_ZAIDX_WORD_LSB +: WW] +: 32];
				default: next_prdata = 32'h0000_0000;
			endcase
		end
		// Unmapped address answers with an error
		if (psel && penable) begin
			case (paddr)
				`UMAC_CTRL_OFF, `UMAC_STATUS_OFF, `UMAC_MASK_OFF,
				`UMAC_INFO_OFF, `UMAC_ZAIDX_OFF, `UMAC_ZADATA_OFF: pslverr = 1'b0;
				default: pslverr = 1'b1;
			endcase
		end
	end

	// Register file flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `UMAC_CTRL_RESET;
			status <= `UMAC_ST_RESET;
			mask <= `UMAC_ST_RESET;
			zaidx <= `UMAC_ZAIDX_RESET;
			prdata <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			status <= next_status;
			mask <= next_mask;
			zaidx <= next_zaidx;
			prdata <= next_prdata;
		end
	end

endmodule // umac_top
`default_nettype wire

// [tb/tb_umac_top.sv]
// Self-checking bench for the widening MAC block
`default_nettype none
`include "umac_regs.svh"
module tb_umac_top
	import umac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals, rows and counters
	// ----------------------------------------
	typedef struct {logic [2:0] ctrl; umac_issue_t op; logic [31:0] x; logic [2:0] res;} umac_row_t;
	typedef logic [31:0] umac_snap_t [16][4];
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, issue_valid, issue_ready;
	logic op_done, op_trap, op_undef, busy, irq, perr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, x_rd_data, q;
	logic [4:0] x_rd_idx, z_rd_idx_a, z_rd_idx_b;
	logic [127:0] z_rd_data_a, z_rd_data_b;
	logic [2:0] res;
	umac_issue_t issue_op;
	umac_row_t rows [11];
	umac_snap_t za0, za1, dz;
	int mismatches, check_count, lat;
	umac_top #(.VL(128)) umac_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .issue_valid(issue_valid),
		.issue_ready(issue_ready), .issue_op(issue_op), .x_rd_idx(x_rd_idx),
		.x_rd_data(x_rd_data), .z_rd_idx_a(z_rd_idx_a), .z_rd_idx_b(z_rd_idx_b),
		.z_rd_data_a(z_rd_data_a), .z_rd_data_b(z_rd_data_b), .op_done(op_done),
		.op_trap(op_trap), .op_undef(op_undef), .busy(busy), .irq(irq));
	umac_rf #(.VL(128)) umac_rf_inst (.x_rd_idx(x_rd_idx), .x_rd_data(x_rd_data),
		.z_rd_idx_a(z_rd_idx_a), .z_rd_idx_b(z_rd_idx_b), .z_rd_data_a(z_rd_data_a),
		.z_rd_data_b(z_rd_data_b));
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tmo();
		mismatches++;
		conclude();
	endtask
	// APB transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			if (n > 20) tmo();
		end while (pready !== 1'b1);
		q = prdata;
		perr = pslverr; // Error answer stands with pready
		{psel, penable} <= 2'b00;
	endtask
	// Whole array through the index and data window
	task automatic snap(output umac_snap_t s);
		for (int r = 0; r < 16; r++) begin
			for (int w = 0; w < 4; w++) begin
				apb(1'b1, `UMAC_ZAIDX_OFF, {16'h0, 8'(w), 8'(r)});
				apb(1'b0, `UMAC_ZADATA_OFF, 32'h0);
				s[r][w] = q;
			end
		end
	endtask
	task automatic issue(input umac_issue_t op);
		int k;
		@(posedge pclk);
		{issue_op, issue_valid} <= {op, 1'b1};
		k = 0;
		do begin
			@(negedge pclk);
			k++;
			if (k > 20) tmo();
		end while (issue_ready !== 1'b1);
		@(posedge pclk);
		issue_valid <= 1'b0;
		lat = 0;
		do begin
			@(negedge pclk);
			lat++;
			res = {op_undef, op_trap, op_done};
			if (lat > 40) tmo();
		end while (res === 3'h0);
	endtask
	// Expected per-lane growth of the array for one row
	task automatic expect_za(input umac_row_t t);
		int g, st, b, n, m, o;
		longint unsigned xs;
		dz = '{default: 32'h0};
		g = 1 << t.op.group_code;
		st = 16 / g;
		o = g == 1 ? 2 * t.op.three_bit_offset_field : 2 * t.op.two_bit_offset_field;
		xs = t.x;
		b = int'((xs + o) % st) & ~1;
		for (int r = 0; r < g && t.res == 3'h1; r++) begin
			n = t.op.multi_src ? (t.op.first_source_field & (g == 2 ? 15 : 7)) * g + r
				: (t.op.first_source_field + r) % 32;
			m = t.op.multi_src ? (t.op.second_source_field & (g == 2 ? 15 : 7)) * g + r
				: t.op.second_source_field;
			for (int i = 0; i < 2; i++) begin
				for (int e = 0; e < 4; e++) begin
					dz[b + r * st + i][e] = umac_rf_inst.zregs[n][32 * e + 16 * i +: 16]
						* umac_rf_inst.zregs[m][32 * e + 16 * i +: 16];
				end
			end
		end
	endtask
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, issue_valid, paddr, pwdata, issue_op} = '0;
		for (int j = 0; j < 32; j++) begin
			umac_rf_inst.xregs[j] = 32'h0;
			for (int k = 0; k < 8; k++) begin
				umac_rf_inst.zregs[j][16 * k +: 16] = 16'(16'hf00f - j * 16'h0731 + k * 16'h0113);
			end
		end
		rows[0] = '{3'h7, '{1'b0, 2'd0, 5'd31, 4'd5, 2'd0, 3'd7, 2'd0}, 32'h3, 3'h1};
		rows[1] = '{3'h7, '{1'b0, 2'd1, 5'd31, 4'd15, 2'd1, 3'd0, 2'd3}, 32'hfffffffe, 3'h1};
		rows[2] = '{3'h7, '{1'b0, 2'd2, 5'd30, 4'd0, 2'd2, 3'd0, 2'd1}, 32'h5, 3'h1};
		rows[3] = '{3'h7, '{1'b1, 2'd1, 5'd31, 4'd7, 2'd3, 3'd0, 2'd2}, 32'h9, 3'h1};
		rows[4] = '{3'h7, '{1'b1, 2'd2, 5'd5, 4'd11, 2'd0, 3'd0, 2'd0}, 32'h100, 3'h1};
		rows[5] = '{3'h7, '{1'b1, 2'd0, 5'd1, 4'd1, 2'd0, 3'd0, 2'd0}, 32'h0, 3'h4};
		rows[6] = '{3'h7, '{1'b0, 2'd3, 5'd1, 4'd1, 2'd0, 3'd0, 2'd0}, 32'h0, 3'h4};
		rows[7] = '{3'h5, '{1'b0, 2'd0, 5'd2, 4'd3, 2'd1, 3'd1, 2'd0}, 32'h0, 3'h2};
		rows[8] = '{3'h3, '{1'b0, 2'd0, 5'd2, 4'd3, 2'd1, 3'd1, 2'd0}, 32'h0, 3'h2};
		rows[9] = '{3'h6, '{1'b0, 2'd0, 5'd2, 4'd3, 2'd1, 3'd1, 2'd0}, 32'h0, 3'h4};
		rows[10] = '{3'h1, '{1'b0, 2'd3, 5'd2, 4'd3, 2'd1, 3'd1, 2'd0}, 32'h0, 3'h4};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `UMAC_CTRL_OFF, 32'h0);
		check(q, 32'h0);
		check(perr, 1'b0);
		apb(1'b1, `UMAC_INFO_OFF, 32'hffffffff);
		apb(1'b0, `UMAC_INFO_OFF, 32'h0);
		check(q, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		check(q, 32'h0);
		check(perr, 1'b1);
		foreach (rows[i]) begin
			apb(1'b1, `UMAC_CTRL_OFF, {29'h0, rows[i].ctrl});
			umac_rf_inst.xregs[{3'b010, rows[i].op.row_select_reg_field}] = rows[i].x;
			snap(za0);
			issue(rows[i].op);
			check(res, rows[i].res);
			check(lat, rows[i].res == 3'h1 ? 1 + 3 * (1 << rows[i].op.group_code) : 1);
			snap(za1);
			expect_za(rows[i]);
			foreach (dz[r, w]) check(za1[r][w] - za0[r][w], dz[r][w]);
			apb(1'b0, `UMAC_STATUS_OFF, 32'h0);
			check(q, {29'h0, rows[i].res});
			apb(1'b1, `UMAC_STATUS_OFF, 32'h7);
		end
		// Masked event keeps irq low until the mask opens
		apb(1'b1, `UMAC_CTRL_OFF, 32'h3);
		issue(rows[8].op);
		@(negedge pclk);
		check(irq, 1'b0);
		apb(1'b1, `UMAC_MASK_OFF, 32'h2);
		@(negedge pclk);
		check(irq, 1'b1);
		apb(1'b1, `UMAC_STATUS_OFF, 32'h2);
		@(negedge pclk);
		check(irq, 1'b0);
		// Back to back: second accept in the done cycle
		apb(1'b1, `UMAC_CTRL_OFF, 32'h7);
		@(posedge pclk);
		{issue_op, issue_valid} <= {rows[0].op, 1'b1};
		repeat (2) @(negedge pclk);
		check(busy, 1'b1);
		repeat (3) @(negedge pclk);
		check(op_done, 1'b1);
		check(issue_ready, 1'b1);
		check(busy, 1'b0);
		@(posedge pclk);
		issue_valid <= 1'b0;
		repeat (4) @(negedge pclk);
		check(op_done, 1'b1);
		conclude();
	end
endmodule // tb_umac_top
`default_nettype wire

// [tb/umac_chk_sva.sv]
// Concurrent checks on the widening MAC issue interface
`default_nettype none
module umac_chk
	import umac_pkg::*;
#(
	parameter int VL = 128 // Vector length in bits
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic issue_valid,
	input wire logic issue_ready,
	input wire umac_issue_t issue_op,
	input wire logic [4:0] x_rd_idx,
	input wire logic [4:0] z_rd_idx_a,
	input wire logic [4:0] z_rd_idx_b,
	input wire logic op_done,
	input wire logic op_trap,
	input wire logic op_undef
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Accept strobe and captured instruction
	// ----------------------------------------
	logic acc;
	logic bad;
	umac_issue_t op_q; // Held for the whole operation
	umac_issue_t next_op_q;
	assign acc = issue_valid && issue_ready;
	assign bad = op_trap || op_undef;
	// Safe to hold: no second accept while busy
	always_comb begin
		next_op_q = acc ? issue_op : op_q;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q <= '0;
		end else begin
			op_q <= next_op_q;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	lat_one_a: assert property (acc && issue_op.group_code == 2'd0 |->
		(##1 bad) or (##4 op_done)) else $error("one group latency wrong");
	lat_two_a: assert property (acc && issue_op.group_code == 2'd1 |->
		(##1 bad) or (##7 op_done)) else $error("two group latency wrong");
	lat_four_a: assert property (acc && issue_op.group_code == 2'd2 |->
		(##1 bad) or (##13 op_done)) else $error("four group latency wrong");
	undef_form_a: assert property (acc && (issue_op.group_code == 2'd3 ||
		(issue_op.multi_src && issue_op.group_code == 2'd0)) |=> op_undef)
		else $error("illegal form not undefined");
	row_reg_a: assert property (x_rd_idx == {3'b010, issue_op.row_select_reg_field})
		else $error("row base register number wrong");
	first_single_a: assert property (acc && !issue_op.multi_src |=> bad ||
		(z_rd_idx_a == op_q.first_source_field
		&& z_rd_idx_b == {1'b0, op_q.second_source_field}))
		else $error("single form source numbers wrong");
	next_single_a: assert property (acc && !issue_op.multi_src &&
		issue_op.group_code == 2'd1 |=> bad or
		(##3 z_rd_idx_a == op_q.first_source_field + 5'd1))
		else $error("second group first source wrong");
	pair_multi_a: assert property (acc && issue_op.multi_src &&
		issue_op.group_code == 2'd1 |=> bad ||
		(z_rd_idx_a == {op_q.first_source_field[3:0], 1'b0}
		&& z_rd_idx_b == {op_q.second_source_field, 1'b0}))
		else $error("multi form source numbers wrong");
	outcome_excl_a: assert property ($onehot0({op_done, op_trap, op_undef}))
		else $error("more than one outcome pulse");
endmodule // umac_chk
bind umac_top umac_chk #(.VL(VL)) umac_chk_inst (.pclk(pclk), .presetn(presetn),
	.issue_valid(issue_valid), .issue_ready(issue_ready), .issue_op(issue_op),
	.x_rd_idx(x_rd_idx), .z_rd_idx_a(z_rd_idx_a), .z_rd_idx_b(z_rd_idx_b),
	.op_done(op_done), .op_trap(op_trap), .op_undef(op_undef));
`default_nettype wire

// [tb/umac_rf.sv]
// Register file model feeding the widening MAC block
`default_nettype none
module umac_rf #(
	parameter int VL = 128 // Vector length in bits
) (
	input wire logic [4:0] x_rd_idx,
	output logic [31:0] x_rd_data,
	input wire logic [4:0] z_rd_idx_a,
	input wire logic [4:0] z_rd_idx_b,
	output logic [VL-1:0] z_rd_data_a,
	output logic [VL-1:0] z_rd_data_b
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Storage, loaded by the bench
	// ----------------------------------------
	logic [31:0] xregs [32]; // General registers
	logic [VL-1:0] zregs [32]; // Vector registers
	// Combinational reads: the block samples in the same cycle
	assign x_rd_data = xregs[x_rd_idx];
	assign z_rd_data_a = zregs[z_rd_idx_a];
	assign z_rd_data_b = zregs[z_rd_idx_b];
endmodule // umac_rf
`default_nettype wire
